//--- hdl/tdmsch_pkg.sv
// Purpose: Shared constants of the time-slot RMAP initiator scheduler.
// Assumes: One 125 MHz clock; time values are 6 bits wide.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package tdmsch_pkg;
	// Time value and slot table
	localparam int TV_W = 6;
	localparam int SLOTS = 64;
	// Clock and start deadline (longest time, rounded down)
	localparam int CLK_NS = 8;
	localparam int START_MAX_NS = 5000;
	localparam int START_CYC_RAW = START_MAX_NS / CLK_NS;
	localparam int START_CYC_INT = (START_CYC_RAW < 1) ? 1 : START_CYC_RAW;
	localparam int WIN_W = 10;
	localparam logic [WIN_W-1:0] START_MAX_CYC = WIN_W'(START_CYC_INT);
	// Data length limit outside multi-slot mode, in bytes
	localparam int LEN_MAX = 256;
	// Schedule modes
	localparam int MODE_W = 2;
	localparam logic [MODE_W-1:0] MODE_SIMPLE = 2'h0;
	localparam logic [MODE_W-1:0] MODE_CONCUR = 2'h1;
	localparam logic [MODE_W-1:0] MODE_MULTI = 2'h2;
	// Reset values
	localparam logic RST_PERMIT = 1'h0;
endpackage : tdmsch_pkg

//--- hdl/tdmsch_top.sv
// Purpose: Time-slot access control for an RMAP initiator: schedule table,
//          time-code watchdog, command gating and reply tracking.
// Assumes: Time-codes, commands and replies come from logic on clk_i.
// Notes: Table is written through a plain port; no software registers.
`timescale 1ns/100ps

module tdmsch_top #(
	parameter int NTGT = 8,
	parameter int SPAN_W = 4,
	parameter int WDG_W = 24,
	parameter int LEN_W = 24,
	parameter int DATA_W = 32,
	parameter int STAT_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Configuration
	input wire logic [tdmsch_pkg::MODE_W-1:0] mode_i,
	input wire logic [WDG_W-1:0] wdog_min_i,
	input wire logic [WDG_W-1:0] wdog_max_i,
	// Schedule table write port
	input wire logic sched_we_i,
	input wire logic [tdmsch_pkg::TV_W-1:0] sched_addr_i,
	input wire logic sched_permit_i,
	input wire logic [NTGT-1:0] sched_tgt_i,
	input wire logic [SPAN_W-1:0] sched_span_i,
	// Time-codes from the link
	input wire logic tc_valid_i,
	input wire logic [tdmsch_pkg::TV_W-1:0] tc_value_i,
	// User command
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic [$clog2(NTGT)-1:0] cmd_tgt_i,
	input wire logic cmd_write_i,
	input wire logic [LEN_W-1:0] cmd_len_i,
	// Command toward the link
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic [$clog2(NTGT)-1:0] tx_tgt_o,
	output logic tx_write_o,
	output logic tx_ack_req_o,
	output logic [LEN_W-1:0] tx_len_o,
	// Reply from the link
	input wire logic rpl_valid_i,
	input wire logic rpl_last_i,
	input wire logic [STAT_W-1:0] rpl_status_i,
	input wire logic [DATA_W-1:0] rpl_data_i,
	// Reply to the user
	output logic usr_rpl_valid_o,
	output logic usr_rpl_last_o,
	output logic [STAT_W-1:0] usr_rpl_status_o,
	output logic [DATA_W-1:0] usr_rpl_data_o,
	// Slot state and errors
	output logic [tdmsch_pkg::TV_W-1:0] slot_o,
	output logic slot_permit_o,
	output logic busy_o,
	output logic err_early_o,
	output logic err_late_o,
	output logic err_noreply_o,
	output logic err_len_o
);
	localparam int TGT_W = $clog2(NTGT);

	generate
		if (NTGT < 2 || SPAN_W < 1 || WDG_W < 2 || LEN_W < 9) begin : g_bad_param
			$error("tdmsch_top: parameter values out of range");
		end
	endgenerate

	logic tbl_permit_ff [tdmsch_pkg::SLOTS];
	logic [NTGT-1:0] tbl_tgt_ff [tdmsch_pkg::SLOTS];
	logic [SPAN_W-1:0] tbl_span_ff [tdmsch_pkg::SLOTS];

	generate
		for (genvar e = 0; e < tdmsch_pkg::SLOTS; e++) begin : g_entry
			wire logic hit = sched_we_i && (sched_addr_i == tdmsch_pkg::TV_W'(e));
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					tbl_permit_ff[e] <= tdmsch_pkg::RST_PERMIT;
					tbl_tgt_ff[e] <= '0;
					tbl_span_ff[e] <= '0;
				end else if (hit) begin
					tbl_permit_ff[e] <= sched_permit_i;
					tbl_tgt_ff[e] <= sched_tgt_i;
					tbl_span_ff[e] <= sched_span_i;
				end
			end
		end
	endgenerate

	logic open_ff;
	logic [tdmsch_pkg::TV_W-1:0] slot_ff;
	logic permit_ff;
	logic [NTGT-1:0] tgt_ff;
	logic [SPAN_W-1:0] span_ff;
	logic issued_ff;
	logic [tdmsch_pkg::WIN_W-1:0] win_ff;
	logic out_ff;
	logic [SPAN_W-1:0] rem_ff;
	logic tx_valid_ff;
	logic [TGT_W-1:0] tx_tgt_ff;
	logic tx_write_ff;
	logic tx_ack_ff;
	logic [LEN_W-1:0] tx_len_ff;
	logic [WDG_W-1:0] itv_ff;
	logic armed_ff;
	logic late_ff;
	logic err_early_ff;
	logic err_late_ff;
	logic err_noreply_ff;
	logic err_len_ff;
	logic rv_ff;
	logic rl_ff;
	logic [STAT_W-1:0] rs_ff;
	logic [DATA_W-1:0] rd_ff;

	wire logic is_multi = (mode_i == tdmsch_pkg::MODE_MULTI);
	wire logic is_simple = (mode_i == tdmsch_pkg::MODE_SIMPLE);
	wire logic len_ok = is_multi || (cmd_len_i <= LEN_W'(tdmsch_pkg::LEN_MAX));
	// Simple schedule lets the slot owner reach any target
	wire logic tgt_ok = is_simple || tgt_ff[cmd_tgt_i];
	// Start only inside the deadline window
	wire logic in_win = (win_ff < tdmsch_pkg::START_MAX_CYC);
	// Send pending command to allowed target
	wire logic accept = cmd_valid_i && !tc_valid_i && open_ff && permit_ff && tgt_ok
		&& !out_ff && !tx_valid_ff && !issued_ff && in_win && len_ok;
	wire logic reject = cmd_valid_i && !len_ok;
	wire logic rpl_done = rpl_valid_i && rpl_last_i && out_ff;
	// Single-slot modes time out at next slot
	// Multi-slot times out after last slot
	wire logic timeout = tc_valid_i && out_ff && (!is_multi || rem_ff == '0);
	wire logic early = tc_valid_i && armed_ff && (itv_ff < wdog_min_i);
	wire logic late = !tc_valid_i && armed_ff && !late_ff && (itv_ff >= wdog_max_i);
	wire logic [SPAN_W-1:0] nxt_rem = (is_multi && span_ff != '0) ? span_ff - SPAN_W'(1) : '0;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			open_ff <= 1'h0;
			slot_ff <= '0;
			permit_ff <= 1'h0;
			tgt_ff <= '0;
			span_ff <= '0;
		end else if (tc_valid_i) begin
			open_ff <= 1'h1;
			slot_ff <= tc_value_i;
			permit_ff <= tbl_permit_ff[tc_value_i];
			tgt_ff <= tbl_tgt_ff[tc_value_i];
			span_ff <= tbl_span_ff[tc_value_i];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			issued_ff <= 1'h0;
			win_ff <= '0;
		end else if (tc_valid_i) begin
			issued_ff <= 1'h0;
			win_ff <= tdmsch_pkg::WIN_W'(1);
		end else begin
			issued_ff <= issued_ff || accept;
			win_ff <= in_win ? win_ff + tdmsch_pkg::WIN_W'(1) : win_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			out_ff <= 1'h0;
			rem_ff <= '0;
		end else if (accept) begin
			out_ff <= 1'h1;
			rem_ff <= nxt_rem;
		end else if (rpl_done || timeout) begin
			out_ff <= 1'h0;
			rem_ff <= '0;
		end else if (tc_valid_i && out_ff) begin
			rem_ff <= rem_ff - SPAN_W'(1);
		end
	end

	// Command stage toward the link; held until taken
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tx_valid_ff <= 1'h0;
			tx_tgt_ff <= '0;
			tx_write_ff <= 1'h0;
			tx_ack_ff <= 1'h0;
			tx_len_ff <= '0;
		end else if (accept) begin
			tx_valid_ff <= 1'h1;
			tx_tgt_ff <= cmd_tgt_i;
			tx_write_ff <= cmd_write_i;
			tx_ack_ff <= cmd_write_i;
			tx_len_ff <= cmd_len_i;
		end else if (tx_ready_i) begin
			tx_valid_ff <= 1'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rv_ff <= 1'h0;
			rl_ff <= 1'h0;
			rs_ff <= '0;
			rd_ff <= '0;
		end else begin
			rv_ff <= rpl_valid_i && out_ff;
			rl_ff <= rpl_done;
			rs_ff <= (rpl_valid_i && out_ff) ? rpl_status_i : rs_ff;
			rd_ff <= (rpl_valid_i && out_ff) ? rpl_data_i : rd_ff;
		end
	end

	// Interval counted in cycles
	// Saturates so a dead link does not wrap into a false early flag
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			itv_ff <= '0;
			armed_ff <= 1'h0;
			late_ff <= 1'h0;
		end else if (tc_valid_i) begin
			itv_ff <= WDG_W'(1);
			armed_ff <= 1'h1;
			late_ff <= 1'h0;
		end else begin
			itv_ff <= (&itv_ff) ? itv_ff : itv_ff + WDG_W'(1);
			late_ff <= late_ff || late;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			err_early_ff <= 1'h0;
			err_late_ff <= 1'h0;
			err_noreply_ff <= 1'h0;
			err_len_ff <= 1'h0;
		end else begin
			err_early_ff <= early;
			err_late_ff <= late;
			err_noreply_ff <= timeout;
			err_len_ff <= reject;
		end
	end

	assign cmd_ready_o = accept || reject;
	assign tx_valid_o = tx_valid_ff;
	assign tx_tgt_o = tx_tgt_ff;
	assign tx_write_o = tx_write_ff;
	assign tx_ack_req_o = tx_ack_ff;
	assign tx_len_o = tx_len_ff;
	assign usr_rpl_valid_o = rv_ff;
	assign usr_rpl_last_o = rl_ff;
	assign usr_rpl_status_o = rs_ff;
	assign usr_rpl_data_o = rd_ff;
	assign slot_o = slot_ff;
	assign slot_permit_o = permit_ff;
	assign busy_o = out_ff;
	assign err_early_o = err_early_ff;
	assign err_late_o = err_late_ff;
	assign err_noreply_o = err_noreply_ff;
	assign err_len_o = err_len_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_pend_at_tc;
		tc_valid_i && out_ff && !is_multi;
	endsequence
	sequence s_abandon;
		err_noreply_o && !busy_o;
	endsequence

	a_slot_number: assert property (tc_valid_i |=> slot_o == $past(tc_value_i))
		else $error("slot number not taken from time-code");
	a_entry_lookup: assert property (tc_valid_i |=> slot_permit_o == $past(tbl_permit_ff[tc_value_i]))
		else $error("permit not looked up on time-code");
	a_start_permit: assert property ($rose(tx_valid_o) |-> $past(permit_ff) && $past(open_ff))
		else $error("command started in unpermitted slot");
	a_start_window: assert property ($rose(tx_valid_o) |-> $past(win_ff) < tdmsch_pkg::START_MAX_CYC)
		else $error("command started after deadline");
	a_write_ack: assert property (tx_valid_o && tx_write_o |-> tx_ack_req_o)
		else $error("write without acknowledge request");
	a_one_slot: assert property (is_simple && issued_ff && !tc_valid_i |=> !$rose(tx_valid_o))
		else $error("second transaction in one slot");
	a_len_limit: assert property ($rose(tx_valid_o) && !is_multi |-> tx_len_o <= LEN_W'(tdmsch_pkg::LEN_MAX))
		else $error("oversize command outside multi-slot");
	a_early_flag: assert property (tc_valid_i && armed_ff && itv_ff < wdog_min_i |=> err_early_o)
		else $error("early time-code not flagged");
	a_late_once: assert property (err_late_o |=> !err_late_o [*2])
		else $error("late flag repeated");
	a_noreply: assert property (s_pend_at_tc |=> s_abandon)
		else $error("missing reply not flagged");
	a_reply_pass: assert property (rpl_valid_i && out_ff |=>
		usr_rpl_valid_o && usr_rpl_data_o == $past(rpl_data_i))
		else $error("reply not passed to user");
endmodule : tdmsch_top

//--- bench/tdmsch_tgt_model.sv
// Purpose: Behavioural far-end target for the scheduler bench.
// Assumes: Takes each command at once; reply words follow lat_i cycles later.
// Notes: Idle reply data is the inverse of the last word, never a held value.
`timescale 1ns/100ps
module tdmsch_tgt_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Command and reply
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic rpl_valid_o,
	output logic rpl_last_o,
	output logic [7:0] rpl_status_o,
	output logic [31:0] rpl_data_o,
	// Behaviour
	input wire logic [9:0] lat_i,
	input wire logic [3:0] nw_i,
	input wire logic mute_i
);
	logic [9:0] wait_ff;
	logic [3:0] left_ff;
	assign tx_ready_o = tx_valid_i;
	assign rpl_valid_o = wait_ff == 10'h000 && left_ff != 4'h0;
	assign rpl_last_o = rpl_valid_o && left_ff == 4'h1;
	assign rpl_status_o = rpl_valid_o ? 8'h00 : 8'hFF;
	assign rpl_data_o = rpl_valid_o ? {28'hC0DE000, left_ff} : ~{28'hC0DE000, 4'h1};
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wait_ff <= 10'h000;
			left_ff <= 4'h0;
		// one transaction served at a time
		end else if (tx_valid_i && !mute_i) begin
			wait_ff <= lat_i;
			left_ff <= nw_i;
		end else if (wait_ff != 10'h000) begin
			wait_ff <= wait_ff - 10'h001;
		end else if (rpl_valid_o) begin
			left_ff <= left_ff - 4'h1;
		end
	end
endmodule : tdmsch_tgt_model

//--- bench/tb.sv
// Purpose: Self-checking bench for the time-slot RMAP initiator scheduler.
// Assumes: Default widths; commands are queued before the opening time-code, except in the length and deadline tests.
// Notes: Watchdog limits of 20 and 3000 cycles keep normal gaps legal.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
	$display("wrong value %s exp %0h got %0h", nm, ex, got); n_mismatch++; end end
module tb;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [1:0] mode_i = 2'h0;
	logic [23:0] wdog_min_i = 24'h000014;
	logic [23:0] wdog_max_i = 24'h000BB8;
	logic sched_we_i = 1'b0;
	logic sched_permit_i = 1'b0;
	logic [5:0] sched_addr_i = 6'h00;
	logic [7:0] sched_tgt_i = 8'h00;
	logic [3:0] sched_span_i = 4'h0;
	logic tc_valid_i = 1'b0;
	logic [5:0] tc_value_i = 6'h00;
	logic cmd_valid_i = 1'b0;
	logic cmd_write_i = 1'b0;
	logic [2:0] cmd_tgt_i = 3'h0;
	logic [23:0] cmd_len_i = 24'h000000;
	logic tx_ready_i, rpl_valid_i, rpl_last_i, cmd_ready_o, tx_valid_o, tx_write_o, tx_ack_req_o;
	logic [7:0] rpl_status_i, usr_rpl_status_o;
	logic [31:0] rpl_data_i, usr_rpl_data_o;
	logic [2:0] tx_tgt_o;
	logic [23:0] tx_len_o;
	logic usr_rpl_valid_o, usr_rpl_last_o, slot_permit_o, busy_o, err_early_o, err_late_o, err_noreply_o, err_len_o;
	logic [5:0] slot_o;
	logic [9:0] tgt_lat = 10'h000;
	logic [3:0] tgt_nw = 4'h1;
	logic tgt_mute = 1'b0;
	int n_mismatch = 0;
	int n_checks = 0;
	tdmsch_top i_tdmsch_top (.*);
	tdmsch_tgt_model i_tdmsch_tgt_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_valid_i(tx_valid_o),
		.tx_ready_o(tx_ready_i), .rpl_valid_o(rpl_valid_i), .rpl_last_o(rpl_last_i), .rpl_status_o(rpl_status_i),
		.rpl_data_o(rpl_data_i), .lat_i(tgt_lat), .nw_i(tgt_nw), .mute_i(tgt_mute));
	always #4 clk_i = ~clk_i;
	task automatic report_and_stop;
		if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic wr(input logic [5:0] a, input logic p, input logic [7:0] m, input logic [3:0] s);
		@(posedge clk_i);
		sched_we_i <= 1'b1;
		sched_addr_i <= a;
		sched_permit_i <= p;
		sched_tgt_i <= m;
		sched_span_i <= s;
		@(posedge clk_i);
		sched_we_i <= 1'b0;
	endtask : wr
	task automatic tc(input logic [5:0] v, input int g);
		repeat (g) @(posedge clk_i);
		tc_valid_i <= 1'b1;
		tc_value_i <= v;
		@(posedge clk_i);
		tc_valid_i <= 1'b0;
		#1;
	endtask : tc
	task automatic cmd(input logic [2:0] t, input logic w, input logic [23:0] l);
		@(posedge clk_i);
		cmd_valid_i <= 1'b1;
		cmd_tgt_i <= t;
		cmd_write_i <= w;
		cmd_len_i <= l;
	endtask : cmd
	task automatic take(input logic e, input int n);
		int k;
		for (k = 0; k < n && cmd_ready_o !== 1'b1; k++) @(negedge clk_i);
		`CHK("cmd_ready_o", e, cmd_ready_o) // taken only when allowed
		if (e) begin
			@(posedge clk_i);
			cmd_valid_i <= 1'b0;
		end
	endtask : take
	task automatic txchk(input logic [2:0] t, input logic w, input logic [23:0] l);
		@(negedge clk_i);
		`CHK("tx_valid_o", 1'b1, tx_valid_o) // leaves one cycle after acceptance
		`CHK("tx_write_o", w, tx_write_o) // pending command sent
		`CHK("tx_ack_req_o", w, tx_ack_req_o) // writes ask for acknowledge
		`CHK("tx_len_o", l, tx_len_o) // length carried
		`CHK("tx_tgt_o", t, tx_tgt_o) // target carried
		`CHK("busy_o", 1'b1, busy_o) // awaiting reply
	endtask : txchk
	task automatic rpl(input int nw);
		int k, c;
		c = 0;
		for (k = 0; k < 700 && usr_rpl_last_o !== 1'b1; k++) begin
			@(negedge clk_i);
			c += int'(usr_rpl_valid_o === 1'b1);
		end
		`CHK("reply words", nw, c) // every word forwarded
		`CHK("usr_rpl_data_o", 32'hC0DE0001, usr_rpl_data_o) // last data word
		`CHK("usr_rpl_last_o", 1'b1, usr_rpl_last_o) // last word marked
		`CHK("usr_rpl_status_o", 8'h00, usr_rpl_status_o) // status
		`CHK("busy_o", 1'b0, busy_o) // done inside the slot
	endtask : rpl
	task automatic t_gate;
		cmd(3'h0, 1'b1, 24'h000100);
		tc(6'h02, 30);
		`CHK("slot_o", 6'h02, slot_o) // slot from time value
		`CHK("slot_permit_o", 1'b0, slot_permit_o) // entry looked up
		take(1'b0, 40); // barred slot
		tc(6'h05, 1);
		`CHK("slot_permit_o", tdmsch_pkg::RST_PERMIT, slot_permit_o) // cleared entry
		take(1'b0, 10); // next slot still barred
	endtask : t_gate
	task automatic t_simple;
		tgt_nw <= 4'h3;
		tc(6'h01, 30);
		`CHK("slot_permit_o", 1'b1, slot_permit_o) // new slot opened
		take(1'b1, 2); // simple mode ignores target set
		txchk(3'h0, 1'b1, 24'h000100); // boundary length
		rpl(3); // reply tracked
	endtask : t_simple
	task automatic t_once;
		cmd(3'h3, 1'b0, 24'h000004);
		take(1'b0, 40); // one transaction per slot
		tgt_lat <= 10'h0C8;
		tc(6'h04, 1);
		take(1'b1, 2); // next permitted slot
		txchk(3'h3, 1'b0, 24'h000004); // read carries no request
		rpl(3); // slow target
	endtask : t_once
	task automatic t_len;
		cmd(3'h0, 1'b1, 24'h000101);
		take(1'b1, 2); // oversize consumed
		#1;
		`CHK("err_len_o", 1'b1, err_len_o) // length flagged
		@(negedge clk_i);
		`CHK("tx_valid_o", 1'b0, tx_valid_o) // nothing sent
	endtask : t_len
	task automatic t_multi;
		@(posedge clk_i);
		mode_i <= tdmsch_pkg::MODE_MULTI;
		tgt_mute <= 1'b1;
		cmd(3'h2, 1'b1, 24'h00012C);
		tc(6'h03, 30);
		take(1'b1, 2); // long transfer in multi-slot
		txchk(3'h2, 1'b1, 24'h00012C);
		tc(6'h05, 30);
		`CHK("err_noreply_o", 1'b0, err_noreply_o) // inside span
		tc(6'h06, 30);
		`CHK("err_noreply_o", 1'b1, err_noreply_o) // span ended
		`CHK("busy_o", 1'b0, busy_o) // abandoned
	endtask : t_multi
	task automatic t_noreply;
		@(posedge clk_i);
		mode_i <= tdmsch_pkg::MODE_SIMPLE;
		cmd(3'h0, 1'b0, 24'h000008);
		tc(6'h01, 30);
		take(1'b1, 2); // sent
		txchk(3'h0, 1'b0, 24'h000008);
		tc(6'h02, 30);
		`CHK("err_noreply_o", 1'b1, err_noreply_o) // missing reply
	endtask : t_noreply
	task automatic t_conc;
		@(posedge clk_i);
		mode_i <= tdmsch_pkg::MODE_CONCUR;
		tgt_mute <= 1'b0;
		tgt_lat <= 10'h000;
		tgt_nw <= 4'h1;
		cmd(3'h5, 1'b1, 24'h000010);
		tc(6'h03, 30);
		take(1'b0, 40); // target outside set
		tc(6'h04, 1);
		take(1'b1, 2); // target inside set
		txchk(3'h5, 1'b1, 24'h000010);
		rpl(1); // prompt target
	endtask : t_conc
	task automatic t_deadline;
		tc(6'h04, 30);
		// Command first seen 625 cycles after the time-code: too late to start
		repeat (623) @(posedge clk_i);
		cmd(3'h0, 1'b1, 24'h000004);
		take(1'b0, 10); // start window closed
	endtask : t_deadline
	task automatic t_wdog;
		int k, c;
		tc(6'h02, 30);
		`CHK("err_early_o", 1'b0, err_early_o) // legal gap
		tc(6'h02, 5);
		`CHK("err_early_o", 1'b1, err_early_o) // early flagged
		@(posedge clk_i);
		wdog_max_i <= 24'h000064;
		tc(6'h02, 30);
		for (k = 0; k < 300 && err_late_o !== 1'b1; k++) @(negedge clk_i);
		`CHK("late cycle", 1'b1, k >= 99 && k <= 103) // late flagged on time
		c = 0;
		repeat (150) begin
			@(negedge clk_i);
			c += int'(err_late_o === 1'b1);
		end
		`CHK("late repeats", 0, c) // flagged once
	endtask : t_wdog
	initial begin
		#400000;
		n_mismatch++;
		report_and_stop;
	end
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(negedge clk_i);
		`CHK("busy_o", 1'b0, busy_o) // nothing outstanding after reset
		`CHK("tx_valid_o", 1'b0, tx_valid_o) // no slot open yet
		wr(6'h01, 1'b1, 8'h02, 4'h1);
		wr(6'h02, 1'b0, 8'hFF, 4'h1);
		wr(6'h03, 1'b1, 8'h04, 4'h2);
		wr(6'h04, 1'b1, 8'hFF, 4'h1);
		t_gate;
		t_simple;
		t_once;
		t_len;
		t_multi;
		t_noreply;
		t_conc;
		t_deadline;
		t_wdog;
		report_and_stop;
	end
endmodule : tb
